// ---- inc/cplfm_pkg.sv ----
package cplfm_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ         = 20_000_000;
   localparam int US_PER_S       = 1_000_000;
   localparam int UNIT_10MS_US   = 10_000;
   localparam int UNIT_100MS_US  = 100_000;
   localparam int UNIT_1S_US     = 1_000_000;
   localparam int CYC_PER_US     = CLK_HZ / US_PER_S;
   localparam int UNIT_10MS_CYC  = UNIT_10MS_US * CYC_PER_US;
   localparam int UNIT_100MS_CYC = UNIT_100MS_US * CYC_PER_US;
   localparam int UNIT_1S_CYC    = UNIT_1S_US * CYC_PER_US;
   localparam int SCALE_10MS     = 100;
   localparam int SCALE_100MS    = 10;
   localparam int SCALE_1S       = 1;
   localparam int AVG_MIN        = 1;
   localparam int AVG_MAX        = 100;
   localparam int AVG_W          = 7;
   localparam int DST_SLOTS      = 4;
   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] A_CTRL     = 8'h00;
   localparam logic [7:0] A_STAT     = 8'h04;
   localparam logic [7:0] A_CUR_LO   = 8'h08;
   localparam logic [7:0] A_CUR_HI   = 8'h0c;
   localparam logic [7:0] A_PRE_LO   = 8'h10;
   localparam logic [7:0] A_PRE_HI   = 8'h14;
   localparam logic [7:0] A_LAT_LO   = 8'h18;
   localparam logic [7:0] A_LAT_HI   = 8'h1c;
   localparam logic [7:0] A_FREQ_CMD = 8'h20;
   localparam logic [7:0] A_GPO      = 8'h24;
   localparam logic [7:0] A_DST      = 8'h30;
   localparam int CTL_EN    = 0;
   localparam int CTL_NEG   = 1;
   localparam int CTL_MODE  = 2;
   localparam int CTL_AONLY = 4;
   localparam int CTL_UNIT  = 5;
   localparam int CTL_CLR   = 7;
   localparam int CTL_AVG   = 8;
   localparam logic [15:0] CTRL_RST = 16'h0100;
   localparam logic [15:0] CTRL_WMASK = 16'h7f7f;
   typedef enum logic [1:0] {MODE_PLAIN, MODE_DIS_PRE, MODE_LAT_PRE, MODE_FREQ} cplfm_mode_t;
   typedef enum logic [1:0] {UNIT_10MS, UNIT_100MS, UNIT_1S} cplfm_unit_t;
endpackage

// ---- inc/cplfm_freq_if.sv ----
interface cplfm_freq_if;
   import cplfm_pkg::*;
   logic               step;
   logic               down;
   logic               restart;
   cplfm_unit_t        unit;
   logic [AVG_W-1:0]   avg;
   logic signed [31:0] freq;
   logic               valid;
   modport ctl   (output step, down, restart, unit, avg, input freq, valid);
   modport meter (input step, down, restart, unit, avg, output freq, valid);
endinterface

// ---- hw/cplfm_freq_meter.sv ----
module cplfm_freq_meter #(
   parameter int P10MS  = cplfm_pkg::UNIT_10MS_CYC,
   parameter int P100MS = cplfm_pkg::UNIT_100MS_CYC,
   parameter int P1S    = cplfm_pkg::UNIT_1S_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   cplfm_freq_if.meter fi
);
   import cplfm_pkg::*;
   logic        [31:0]      tcnt;
   logic        [31:0]      per;
   logic        [6:0]       scale;
   logic        [AVG_W-1:0] n;
   logic                    tick;
   logic                    upd;
   logic signed [31:0]      acc;
   logic signed [31:0]      sample;
   logic signed [31:0]      ring [AVG_MAX];
   logic        [AVG_W-1:0] ptr;
   logic        [AVG_W-1:0] filled;
   logic signed [39:0]      sum;
   logic signed [47:0]      num;
   logic                    rearm;
   cplfm_unit_t             unit_q;
   logic        [AVG_W-1:0] n_q;
   // -----------------------------------------------------------------
   // Unit time divider
   // -----------------------------------------------------------------
   always_comb
   begin
      unique case (fi.unit)
         UNIT_10MS:  begin per = 32'(P10MS);  scale = 7'(SCALE_10MS);  end
         UNIT_100MS: begin per = 32'(P100MS); scale = 7'(SCALE_100MS); end
         default:    begin per = 32'(P1S);    scale = 7'(SCALE_1S);    end
      endcase
      if (fi.avg < AVG_W'(AVG_MIN))
         n = AVG_W'(AVG_MIN);
      else if (fi.avg > AVG_W'(AVG_MAX))
         n = AVG_W'(AVG_MAX);
      else
         n = fi.avg;
      sample = acc + (fi.step ? (fi.down ? -32'sd1 : 32'sd1) : 32'sd0);
      num = 48'(sum) * $signed({41'h0, scale});
   end
   // Unit or averaging change starts afresh, no stale window or ring
   always_ff @(posedge clk_i)
      if (rst_i)
      begin
         unit_q <= UNIT_10MS;
         n_q    <= AVG_W'(AVG_MIN);
      end
      else
      begin
         unit_q <= fi.unit;
         n_q    <= n;
      end
   assign rearm = fi.restart || fi.unit != unit_q || n != n_q;
   assign tick = (tcnt == per - 32'd1);
   always_ff @(posedge clk_i)
      if (rst_i || rearm || tick)
         tcnt <= '0;
      else
         tcnt <= tcnt + 32'd1;
   // -----------------------------------------------------------------
   // Count per unit and moving average
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i)
      if (rst_i || rearm)
         acc <= '0;
      else
         acc <= tick ? 32'sd0 : sample;
   always_ff @(posedge clk_i)
      if (rst_i || rearm)
      begin
         sum    <= '0;
         ptr    <= '0;
         filled <= '0;
         upd    <= 1'b0;
      end
      else
      begin
         upd <= tick;
         if (tick)
         begin
            sum <= sum + 40'(sample) - ((filled >= n) ? 40'(ring[ptr]) : 40'sd0);
            ptr <= (ptr == n - AVG_W'(1)) ? '0 : ptr + AVG_W'(1);
            if (filled < n)
               filled <= filled + AVG_W'(1);
         end
      end
   always_ff @(posedge clk_i)
      if (tick)
         ring[ptr] <= sample;
   always_ff @(posedge clk_i)
      if (rst_i || rearm)
      begin
         fi.freq  <= '0;
         fi.valid <= 1'b0;
      end
      else if (upd && filled >= n)
      begin
         fi.freq  <= 32'(num / $signed(48'(n)));
         fi.valid <= 1'b1;
      end
   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_avg_store: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(fi.valid) |-> $past(filled) >= n)
      else $error("frequency stored before averaging window filled");
   a_zero_freq: assert property (@(posedge clk_i) disable iff (rst_i)
      upd && filled >= n && sum == 40'sd0 |=> fi.freq == 32'sd0)
      else $error("zero count gave nonzero frequency");
   c_freq_valid: cover property (@(posedge clk_i) disable iff (rst_i) $rose(fi.valid));
endmodule

// ---- hw/cplfm_top.sv ----
// Functional notes
// - Stop or latch and preset follow function input edges alone.
// - Disable/preset mode counts once count enable is set.
// - Active edge of function input halts counting, value held.
// - Release edge loads preset into current value, counting resumes.
// - Preset write replaces stored preset, current value untouched.
// - Count enable clear stops counting whatever function input does.
// - Enable while function input active stays halted until release.
// - Function input polarity selectable, positive after reset.
// - External preset request flag set suppresses preset actions.
// - Flag clear command clears the flag, preset works again.
// - Latch/preset mode active edge latches current then loads preset.
// - Latch value 1 stays readable by the latch read command.
// - Latch/preset mode count enable halts and resumes counting.
// - Frequency mode counts phase A/B pulses and derives frequency.
// - Frequency command delivers result to software-chosen slot.
// - Frequency mode frees phase Z, function, latch, coincidence pins.
// - A-only source in frequency mode frees phase B as plain input.
// - Unit time 0.01, 0.1 or 1 s; signed frequency, zero if none.
// - Moving average 1 to 100, stored after that many measurements.
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
module cplfm_top #(
   parameter int P10MS  = cplfm_pkg::UNIT_10MS_CYC,
   parameter int P100MS = cplfm_pkg::UNIT_100MS_CYC,
   parameter int P1S    = cplfm_pkg::UNIT_1S_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        phase_a_i,
   input  wire logic        phase_b_i,
   input  wire logic        phase_z_i,
   input  wire logic        func_i,
   input  wire logic        latch_in_i,
   output logic      [1:0]  gpo_o,
   output logic             ext_preset_request_flag_o
);
   import cplfm_pkg::*;
   logic        [15:0]      ctrl;
   logic        [1:0]       gpo;
   logic        [31:0]      pre_lo_hold;
   logic signed [31:0]      preset;
   logic signed [31:0]      cur;
   logic signed [31:0]      latch;
   logic signed [31:0]      dst [DST_SLOTS];
   logic                    flag;
   logic                    a_q;
   logic                    f_q;
   logic                    z_q;
   logic                    count_enable_cmd;
   logic                    func_act;
   logic                    a_rise;
   logic                    f_rise;
   logic                    f_fall;
   logic                    z_rise;
   logic                    down;
   logic                    run;
   logic                    lp_ev;
   logic                    dp_load;
   logic                    req;
   logic                    wr;
   logic                    clr_cmd;
   logic [31:0]             wdat;
   logic [31:0]             ctrl_merged;
   logic [31:0]             next_rdat;
   logic [3:0]              gp_in;
   cplfm_mode_t             mode;
   cplfm_freq_if            fi ();
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction
   // -----------------------------------------------------------------
   // Wishbone slave
   // -----------------------------------------------------------------
   assign req = wb_cyc_i && wb_stb_i;
   assign wr = req && wb_we_i && wb_ack_o;
   always_ff @(posedge clk_i)
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= req && !wb_ack_o;
   always_comb
   begin
      unique case (wb_adr_i)
         A_CTRL:   next_rdat = {16'h0, ctrl};
         A_STAT:   next_rdat = {20'h0, gp_in, 5'h0, run, fi.valid, flag};
         A_CUR_LO: next_rdat = cur;
         A_CUR_HI: next_rdat = {32{cur[31]}};
         A_PRE_LO: next_rdat = preset;
         A_PRE_HI: next_rdat = {32{preset[31]}};
         A_LAT_LO: next_rdat = latch;
         A_LAT_HI: next_rdat = {32{latch[31]}};
         A_GPO:    next_rdat = {30'h0, gpo};
         default:
            if (wb_adr_i[7:4] == A_DST[7:4])
               next_rdat = dst[wb_adr_i[3:2]];
            else
               next_rdat = '0;
      endcase
   end
   always_ff @(posedge clk_i)
      if (rst_i)
         wb_dat_o <= '0;
      else if (req && !wb_ack_o)
         wb_dat_o <= next_rdat;
   assign wdat = merge(32'h0, wb_dat_i, wb_sel_i);
   assign ctrl_merged = merge({16'h0, ctrl}, wb_dat_i, wb_sel_i);
   assign clr_cmd = wr && wb_adr_i == A_CTRL && wb_sel_i[0] && wb_dat_i[CTL_CLR];
   // -----------------------------------------------------------------
   // Configuration registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i)
      if (rst_i)
         ctrl <= CTRL_RST;
      else if (wr && wb_adr_i == A_CTRL)
         ctrl <= ctrl_merged[15:0] & CTRL_WMASK;
   always_ff @(posedge clk_i)
      if (rst_i)
         gpo <= '0;
      else if (wr && wb_adr_i == A_GPO)
         gpo <= wdat[1:0];
   always_ff @(posedge clk_i)
      if (rst_i)
      begin
         pre_lo_hold <= '0;
         preset      <= '0;
      end
      else if (wr && wb_adr_i == A_PRE_LO)
         pre_lo_hold <= merge(pre_lo_hold, wb_dat_i, wb_sel_i);
      else if (wr && wb_adr_i == A_PRE_HI)
         preset <= pre_lo_hold;
   assign count_enable_cmd = ctrl[CTL_EN];
   assign mode = cplfm_mode_t'(ctrl[CTL_MODE +: 2]);
   // -----------------------------------------------------------------
   // Input edges
   // -----------------------------------------------------------------
   assign func_act = func_i ^ ctrl[CTL_NEG];
   always_ff @(posedge clk_i)
      if (rst_i)
      begin
         a_q <= 1'b0;
         f_q <= 1'b0;
         z_q <= 1'b0;
      end
      else
      begin
         a_q <= phase_a_i;
         f_q <= func_act;
         z_q <= phase_z_i;
      end
   assign a_rise = phase_a_i && !a_q;
   assign f_rise = func_act && !f_q;
   assign f_fall = !func_act && f_q;
   assign z_rise = phase_z_i && !z_q && mode != MODE_FREQ;
   assign down = phase_b_i && !ctrl[CTL_AONLY];
   // -----------------------------------------------------------------
   // Counting, preset and latch
   // -----------------------------------------------------------------
   assign run = count_enable_cmd && mode != MODE_FREQ
                && !(mode == MODE_DIS_PRE && func_act);
   assign lp_ev = mode == MODE_LAT_PRE && f_rise;
   assign dp_load = mode == MODE_DIS_PRE && f_fall && !flag;
   always_ff @(posedge clk_i)
      if (rst_i)
         cur <= '0;
      else if ((lp_ev && !flag) || dp_load)
         cur <= preset;
      else if (run && a_rise)
         cur <= down ? cur - 32'sd1 : cur + 32'sd1;
   always_ff @(posedge clk_i)
      if (rst_i)
         latch <= '0;
      else if (lp_ev)
         latch <= cur;
   always_ff @(posedge clk_i)
      if (rst_i)
         flag <= 1'b0;
      else if (z_rise)
         flag <= 1'b1;
      else if (clr_cmd)
         flag <= 1'b0;
   assign ext_preset_request_flag_o = flag;
   // -----------------------------------------------------------------
   // Frequency measurement
   // -----------------------------------------------------------------
   assign fi.step = mode == MODE_FREQ && a_rise;
   assign fi.down = down;
   assign fi.restart = mode != MODE_FREQ;
   assign fi.unit = cplfm_unit_t'(ctrl[CTL_UNIT +: 2]);
   assign fi.avg = ctrl[CTL_AVG +: AVG_W];
   cplfm_freq_meter #(
      .P10MS  (P10MS),
      .P100MS (P100MS),
      .P1S    (P1S)
   ) i_cplfm_freq_meter (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .fi    (fi)
   );
   always_ff @(posedge clk_i)
      if (rst_i)
         for (int i = 0; i < DST_SLOTS; i++)
            dst[i] <= '0;
      else if (wr && wb_adr_i == A_FREQ_CMD)
         dst[wb_dat_i[1:0]] <= fi.freq;
   // Pins left to plain use in frequency mode
   assign gp_in = (mode == MODE_FREQ)
                  ? {latch_in_i, func_i, phase_z_i, phase_b_i && ctrl[CTL_AONLY]}
                  : 4'h0;
   always_ff @(posedge clk_i)
      if (rst_i)
         gpo_o <= '0;
      else
         gpo_o <= (mode == MODE_FREQ) ? gpo : 2'b00;
   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_en_off_hold: assert property (!count_enable_cmd && !lp_ev && !dp_load
      |=> $stable(cur))
      else $error("counter moved with count enable off");
   a_func_halt: assert property (mode == MODE_DIS_PRE && func_act && $stable(ctrl)
      |=> $stable(cur))
      else $error("counter moved while function input active");
   a_release_load: assert property (dp_load |=> cur == $past(preset))
      else $error("preset not loaded on release edge");
   a_flag_blocks: assert property (mode == MODE_DIS_PRE && f_fall && flag && !a_rise
      |=> $stable(cur))
      else $error("preset loaded while request flag set");
   a_latch_cap: assert property (lp_ev |=> latch == $past(cur))
      else $error("latch value not captured");
   a_latch_pre: assert property (lp_ev && !flag |=> cur == $past(preset))
      else $error("preset not loaded after latch");
   a_preset_wr: assert property (wr && wb_adr_i == A_PRE_HI
      |=> preset == $past(pre_lo_hold))
      else $error("preset write lost");
   a_flag_clear: assert property (clr_cmd && !z_rise |=> !flag)
      else $error("request flag not cleared");
   a_count_up: assert property (run && a_rise && !down && !lp_ev && !dp_load
      |=> cur == $past(cur) + 32'sd1)
      else $error("counter did not step");
   a_wb_ack: assert property (req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not one cycle");
   c_dis_load: cover property (dp_load);
   c_latch_ev: cover property (lp_ev && !flag);
   c_freq_cmd: cover property (wr && wb_adr_i == A_FREQ_CMD && fi.valid);
endmodule

// ---- testbench/cplfm_pulse_src.sv ----
module cplfm_pulse_src (
   input  wire logic clk_i,
   output logic      phase_a_o,
   output logic      phase_b_o,
   output logic      phase_z_o,
   output logic      func_o,
   output logic      latch_in_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic burst_a;
   logic rate_a;
   int   period;
   int   cnt;
   initial
   begin
      burst_a = 1'b0;
      rate_a = 1'b0;
      period = 0;
      cnt = 0;
      phase_b_o = 1'b0;
      phase_z_o = 1'b0;
      func_o = 1'b0;
      latch_in_o = 1'b0;
   end
   // ----------------------------------------------------------------
   // Free-running pulse train, one high cycle per period
   // ----------------------------------------------------------------
   always @(posedge clk_i)
   begin
      cnt <= (period != 0 && cnt + 1 < period) ? cnt + 1 : 0;
      rate_a <= (period != 0 && cnt == 0);
   end
   assign phase_a_o = burst_a | rate_a;
   task automatic set_rate(input int p);
      @(posedge clk_i);
      period <= p;
   endtask
   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         burst_a <= 1'b1;
         @(posedge clk_i);
         burst_a <= 1'b0;
      end
      repeat (2) @(posedge clk_i);
   endtask
   // Pin 0 function, 1 phase Z, 2 phase B, 3 latch input
   task automatic set_pin(input int which, input logic v);
      @(posedge clk_i);
      case (which)
         0: func_o <= v;
         1: phase_z_o <= v;
         2: phase_b_o <= v;
         default: latch_in_o <= v;
      endcase
      repeat (3) @(posedge clk_i);
   endtask
endmodule

// ---- testbench/cplfm_top_bench.sv ----
module cplfm_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import cplfm_pkg::*;
   localparam logic [31:0] PRE = 32'hfffffff6;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'hf;
   logic [31:0] wb_dat_w = 32'h0;
   logic [31:0] wb_dat_r;
   logic        wb_ack;
   logic        pa, pb, pz, fn, li;
   logic [1:0]  gpo;
   logic        flag;
   logic [31:0] r;
   int          error_cnt = 0;
   int          tests_run = 0;
   always #25 clk_i = ~clk_i;
   cplfm_top #(.P10MS(20), .P100MS(200), .P1S(2000)) i_cplfm_top (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
      .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .phase_a_i(pa), .phase_b_i(pb),
      .phase_z_i(pz), .func_i(fn), .latch_in_i(li), .gpo_o(gpo),
      .ext_preset_request_flag_o(flag));
   cplfm_pulse_src i_cplfm_pulse_src (.clk_i(clk_i), .phase_a_o(pa), .phase_b_o(pb),
      .phase_z_o(pz), .func_o(fn), .latch_in_o(li));
   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
                          input logic [3:0] sel, output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_dat_w <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 16);
      if (wb_ack !== 1'b1)
      begin
         error_cnt++;
         $display("mismatch wb_ack expected 1 seen %b", wb_ack);
         close_out();
      end
      rd = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      // Let outputs updated by the write settle before callers look
      @(negedge clk_i);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] dummy;
      wb_xfer(1'b1, adr, d, 4'hf, dummy);
   endtask
   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_pin(input string nm, input logic [1:0] e, input logic [1:0] g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e, input string nm);
      wb_xfer(1'b0, adr, 32'h0, 4'hf, r);
      chk32(nm, e, r);
   endtask
   task automatic cur_is(input logic [31:0] e);
      rd_chk(A_CUR_LO, e, "cur_lo");
   endtask
   task automatic meas(input logic [1:0] s, input int w, input logic [31:0] e);
      repeat (w) @(posedge clk_i);
      wr(A_FREQ_CMD, {30'h0, s});
      rd_chk(A_DST + {4'h0, s, 2'b00}, e, "freq_slot");
   endtask
   task automatic done(input string nm);
      $display("test %s done", nm);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(A_CTRL, 32'h00000100, "ctrl_reset");
      rd_chk(A_STAT, 32'h0, "stat_reset");
      wr(8'h40, 32'hffffffff);
      rd_chk(8'h40, 32'h0, "unmapped");
      wb_xfer(1'b1, A_PRE_LO, PRE & 32'hffff0000, 4'hc, r);
      wb_xfer(1'b1, A_PRE_LO, PRE & 32'h0000ffff, 4'h3, r);
      wr(A_PRE_HI, 32'h0);
      cur_is(32'h0);
      rd_chk(A_PRE_LO, PRE, "pre_lo");
      rd_chk(A_PRE_HI, 32'hffffffff, "pre_hi");
      repeat (40000) @(posedge clk_i);
      done("preset");
      wr(A_CTRL, 32'h0105);
      i_cplfm_pulse_src.pulses(5);
      cur_is(32'h5);
      i_cplfm_pulse_src.set_pin(0, 1'b1);
      i_cplfm_pulse_src.pulses(3);
      cur_is(32'h5);
      i_cplfm_pulse_src.set_pin(0, 1'b0);
      cur_is(PRE);
      i_cplfm_pulse_src.pulses(2);
      cur_is(PRE + 32'h2);
      rd_chk(A_CUR_HI, 32'hffffffff, "cur_hi");
      wr(A_CTRL, 32'h0104);
      i_cplfm_pulse_src.pulses(3);
      cur_is(PRE + 32'h2);
      i_cplfm_pulse_src.set_pin(0, 1'b1);
      wr(A_CTRL, 32'h0105);
      i_cplfm_pulse_src.pulses(2);
      cur_is(PRE + 32'h2);
      i_cplfm_pulse_src.set_pin(0, 1'b0);
      cur_is(PRE);
      done("disable_preset");
      wr(A_CTRL, 32'h0107);
      i_cplfm_pulse_src.pulses(2);
      cur_is(PRE);
      i_cplfm_pulse_src.set_pin(0, 1'b1);
      i_cplfm_pulse_src.pulses(3);
      cur_is(PRE + 32'h3);
      i_cplfm_pulse_src.set_pin(0, 1'b0);
      i_cplfm_pulse_src.pulses(1);
      cur_is(PRE + 32'h3);
      i_cplfm_pulse_src.set_pin(0, 1'b1);
      cur_is(PRE);
      done("negative_logic");
      i_cplfm_pulse_src.pulses(2);
      i_cplfm_pulse_src.set_pin(1, 1'b1);
      i_cplfm_pulse_src.set_pin(1, 1'b0);
      chk_pin("flag_pin", 2'b01, {1'b0, flag});
      rd_chk(A_STAT, 32'h5, "stat_flag");
      i_cplfm_pulse_src.set_pin(0, 1'b0);
      i_cplfm_pulse_src.set_pin(0, 1'b1);
      cur_is(PRE + 32'h2);
      wr(A_CTRL, 32'h0187);
      chk_pin("flag_pin", 2'b00, {1'b0, flag});
      i_cplfm_pulse_src.set_pin(0, 1'b0);
      i_cplfm_pulse_src.set_pin(0, 1'b1);
      cur_is(PRE);
      done("flag");
      i_cplfm_pulse_src.set_pin(0, 1'b0);
      wr(A_CTRL, 32'h0109);
      wr(A_GPO, 32'h3);
      chk_pin("gpo", 2'b00, gpo);
      i_cplfm_pulse_src.pulses(4);
      i_cplfm_pulse_src.set_pin(0, 1'b1);
      rd_chk(A_LAT_LO, PRE + 32'h4, "lat_lo");
      rd_chk(A_LAT_HI, 32'hffffffff, "lat_hi");
      cur_is(PRE);
      i_cplfm_pulse_src.pulses(2);
      i_cplfm_pulse_src.set_pin(0, 1'b0);
      wr(A_CTRL, 32'h0108);
      i_cplfm_pulse_src.pulses(3);
      cur_is(PRE + 32'h2);
      wr(A_CTRL, 32'h0109);
      i_cplfm_pulse_src.pulses(1);
      cur_is(PRE + 32'h3);
      rd_chk(A_LAT_LO, PRE + 32'h4, "lat_lo");
      i_cplfm_pulse_src.set_pin(1, 1'b1);
      i_cplfm_pulse_src.set_pin(1, 1'b0);
      i_cplfm_pulse_src.set_pin(0, 1'b1);
      rd_chk(A_LAT_LO, PRE + 32'h3, "lat_lo");
      cur_is(PRE + 32'h3);
      wr(A_CTRL, 32'h0189);
      done("latch_preset");
      wr(A_CTRL, 32'h010d);
      i_cplfm_pulse_src.set_pin(1, 1'b1);
      i_cplfm_pulse_src.set_pin(3, 1'b1);
      chk_pin("flag_pin", 2'b00, {1'b0, flag});
      chk_pin("gpo", 2'b11, gpo);
      wb_xfer(1'b0, A_STAT, 32'h0, 4'hf, r);
      chk32("stat_gp", 32'he, {28'h0, r[11:8]});
      i_cplfm_pulse_src.set_rate(4);
      for (int u = 0; u < 3; u++)
      begin
         wr(A_CTRL, 32'h010d | {25'h0, u[1:0], 5'h0});
         meas(u[1:0], (u == 0) ? 60 : (u == 1) ? 420 : 4020, 32'd500);
      end
      rd_chk(A_STAT, 32'h0e02, "stat_valid");
      wr(A_CTRL, 32'h010d);
      i_cplfm_pulse_src.set_pin(2, 1'b1);
      meas(2'h3, 60, -32'sd500);
      wr(A_CTRL, 32'h011d);
      meas(2'h0, 60, 32'd500);
      wb_xfer(1'b0, A_STAT, 32'h0, 4'hf, r);
      chk32("stat_b", 32'h1, {31'h0, r[8]});
      i_cplfm_pulse_src.set_rate(0);
      meas(2'h1, 60, 32'h0);
      i_cplfm_pulse_src.set_rate(4);
      wr(A_CTRL, 32'h041d);
      // Two of four windows done: no averaged result yet
      repeat (50) @(posedge clk_i);
      wb_xfer(1'b0, A_STAT, 32'h0, 4'hf, r);
      chk32("stat_avg", 32'h0, {31'h0, r[1]});
      meas(2'h2, 200, 32'd500);
      done("frequency");
      close_out();
   end
endmodule
